/* File: bench/ewp_link_assertions.sv */
// assertions on the two-wire link between controller and target
`timescale 1ns/1ps
`default_nettype none
module ewp_link_assertions #(
    parameter int PROG_CYC = 200,
    parameter int QTR_CYC  = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // link and status
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe,
    input wire logic program_busy
);
    localparam int A_LO = 3 * QTR_CYC - 8;
    localparam int A_HI = 5 * QTR_CYC - 8;
    typedef struct packed {
        logic scl_q; logic sda_q; logic in_frame; logic [4:0] stop_age; logic [15:0] bcnt;
    } ewp_mon_type;
    ewp_mon_type mon_ff, nxt_mon;
    // frame tracking, cycles since stop, program length
    always_comb begin
        nxt_mon = mon_ff;
        nxt_mon.scl_q = scl;
        nxt_mon.sda_q = sda;
        if (mon_ff.stop_age != 5'h1f) nxt_mon.stop_age = mon_ff.stop_age + 5'h1;
        if (scl && mon_ff.scl_q && !sda && mon_ff.sda_q) nxt_mon.in_frame = 1'b1;
        if (scl && mon_ff.scl_q && sda && !mon_ff.sda_q) begin
            nxt_mon.in_frame = 1'b0;
            nxt_mon.stop_age = 5'h0;
        end
        nxt_mon.bcnt = program_busy ? mon_ff.bcnt + 16'h1 : 16'h0;
    end
    always_ff @(posedge clk_sys) begin
        if (srst) mon_ff <= {1'b1, 1'b1, 1'b0, 5'h1f, 16'h0};
        else mon_ff <= nxt_mon;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_quiet; program_busy |-> !dev_sda_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("target drove link while busy");
    property p_len;
        $fell(program_busy) |-> (mon_ff.bcnt >= PROG_CYC && mon_ff.bcnt <= PROG_CYC + 2)
            || (mon_ff.bcnt >= 2 * PROG_CYC && mon_ff.bcnt <= 2 * PROG_CYC + 2);
    endproperty
    a_len: assert property (p_len) else $error("program length wrong");
    property p_launch; $rose(program_busy) |-> mon_ff.stop_age < 5'h0c; endproperty
    a_launch: assert property (p_launch) else $error("program without stop");
    property p_closed; $rose(program_busy) |-> !mon_ff.in_frame; endproperty
    a_closed: assert property (p_closed) else $error("program inside frame");
    property p_busy_min; $rose(program_busy) |=> program_busy[*8]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("program cut short");
    property p_ack_len;
        $rose(dev_sda_oe) |-> dev_sda_oe[*8] ##[A_LO:A_HI] $fell(dev_sda_oe);
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack not one bit long");
    property p_ack_hold; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack moved with clock high");
    property p_ack_frame; dev_sda_oe |-> mon_ff.in_frame; endproperty
    a_ack_frame: assert property (p_ack_frame) else $error("ack outside frame");
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// bench: apb-driven controller writing the target over the link
`timescale 1ns/1ps
`default_nettype none
`include "ewp_consts.svh"
module tb_top;
    localparam int PC = 2000;
    logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, serr, mode, inh, prot, program_busy;
    logic [1:0] cs = 2'h0;
    int err_total = 0, checks = 0, cyc = 0, pcnt = 0, plen = 0;
    always #20 clk_sys = ~clk_sys;
    ewp_link_if lnk();
    ewp_ctrl #(.QTR_CYC(8)) i_ewp_ctrl (.clk_sys(clk_sys), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(lnk.controller), .multibyte_mode(mode),
        .write_inhibit_input(inh), .protect_enable(prot));
    ewp_target #(.PROG_CYC(PC)) i_ewp_target (.clk_sys(clk_sys), .srst(srst),
        .link(lnk.target), .chip_select_low_bit(cs[0]), .chip_select_high_bit(cs[1]),
        .multibyte_mode(mode), .write_inhibit_input(inh), .protect_enable(prot),
        .program_busy(program_busy));
    ewp_link_assertions #(.PROG_CYC(PC), .QTR_CYC(8)) i_ewp_link_assertions (
        .clk_sys(clk_sys), .srst(srst), .scl(lnk.scl), .sda(lnk.sda),
        .dev_sda_oe(lnk.dev_sda_oe), .program_busy(program_busy));
    // program length monitor and hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (program_busy === 1'b1) pcnt <= pcnt + 1;
        else if (pcnt != 0) begin plen <= pcnt; pcnt <= 0; end
        if (cyc == 90000) begin err_total++; give_verdict(); end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin err_total++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // waits are bounded by the hang guard only
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata; serr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // one write frame, then poll until the controller is idle
    task automatic xfer(input logic [2:0] sel, input logic [2:0] cnt, input logic [7:0] ad);
        bus(1'b1, `EWP_REG_ADDR, {24'h00_0000, ad});
        bus(1'b1, `EWP_REG_DLO, 32'h4433_2211);
        bus(1'b1, `EWP_REG_CMD, {25'h000_0000, sel, cnt, 1'b1});
        do bus(1'b0, `EWP_REG_STAT, 32'h0); while (rd[0] !== 1'b0);
    endtask
    task automatic settle();
        while (program_busy !== 1'b0) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        bus(1'b0, `EWP_REG_STAT, 32'h0);
        chk("stat", 32'h0, rd);
        bus(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, serr});
        chk("unmapped data", 32'h0, rd);
        bus(1'b1, `EWP_REG_PINS, 32'h7);
        bus(1'b0, `EWP_REG_PINS, 32'h0);
        chk("pins", 32'h7, rd);
        bus(1'b1, `EWP_REG_PINS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            cs <= i[1:0];
            xfer({1'b0, ~i[1:0]}, 3'h0, 8'h10);
            chk("cs mismatch", 32'h1, {31'h0, rd[1]});
            xfer({1'b0, i[1:0]}, 3'h0, 8'h10);
            chk("byte write", 32'h0, {31'h0, rd[1]});
            xfer({1'b0, i[1:0]}, 3'h0, 8'h10);
            chk("poll busy", 32'h1, {31'h0, rd[1]});
            settle();
            chk("byte time", 32'h1, plen / PC);
        end
        cs <= 2'h0;
        chk("byte data", 32'h11, {24'h0, i_ewp_target.r_ff.mem[9'h010]});
        bus(1'b1, `EWP_REG_PINS, 32'h1);
        xfer(3'h0, 3'h3, 8'h02);
        chk("multi ack", 32'h0, {31'h0, rd[1]});
        settle();
        chk("two row time", 32'h2, plen / PC);
        chk("multi data", 32'h44, {24'h0, i_ewp_target.r_ff.mem[9'h005]});
        xfer(3'h0, 3'h3, 8'h08);
        settle();
        chk("one row time", 32'h1, plen / PC);
        bus(1'b1, `EWP_REG_PINS, 32'h0);
        xfer(3'h0, 3'h7, 8'h06);
        chk("page ack", 32'h0, {31'h0, rd[1]});
        settle();
        chk("page time", 32'h1, plen / PC);
        chk("page wrap", 32'h33, {24'h0, i_ewp_target.r_ff.mem[9'h000]});
        xfer(3'h4, 3'h0, 8'hff);
        settle();
        chk("ptr plain", 32'h11, {24'h0, i_ewp_target.r_ff.mem[9'h1ff]});
        bus(1'b1, `EWP_REG_PINS, 32'h4);
        xfer(3'h4, 3'h0, 8'h20);
        chk("prot ack", 32'h0, {31'h0, rd[1]});
        settle();
        chk("protected", 32'hff, {24'h0, i_ewp_target.r_ff.mem[9'h120]});
        xfer(3'h4, 3'h0, 8'h08);
        settle();
        chk("below bound", 32'h11, {24'h0, i_ewp_target.r_ff.mem[9'h108]});
        bus(1'b1, `EWP_REG_PINS, 32'h6);
        xfer(3'h4, 3'h0, 8'h00);
        chk("inhibit ack", 32'h0, {31'h0, rd[1]});
        settle();
        chk("inhibited", 32'hff, {24'h0, i_ewp_target.r_ff.mem[9'h100]});
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: hdl/ewp_consts.svh */
// constants shared by both ends of the protected memory link
`ifndef EWP_CONSTS_SVH
`define EWP_CONSTS_SVH
`define EWP_TYPE_ID    4'b1010
`define EWP_PTR_ADDR   9'h1ff
`define EWP_FLAG_BIT   2
`define EWP_MEM_FILL   8'hff
`define EWP_CLK_NS     40
`define EWP_PROG_NS    10000000
`define EWP_PROG_CYC   (`EWP_PROG_NS / `EWP_CLK_NS)
`define EWP_SCL_NS     10000
`define EWP_QTR_CYC    (`EWP_SCL_NS / `EWP_CLK_NS / 4)
`define EWP_REG_CMD    8'h00
`define EWP_REG_ADDR   8'h04
`define EWP_REG_DLO    8'h08
`define EWP_REG_DHI    8'h0c
`define EWP_REG_STAT   8'h10
`define EWP_REG_PINS   8'h14
`define EWP_CMD_GO     0
`define EWP_CMD_CNT    3:1
`define EWP_CMD_SEL    6:4
`define EWP_STAT_BUSY  0
`define EWP_STAT_NACK  1
`endif

/* File: hdl/ewp_ctrl.sv */
// controller end: apb registers and serial write sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ewp_consts.svh"
module ewp_ctrl #(
    parameter int QTR_CYC = `EWP_QTR_CYC
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          srst,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // serial link
    ewp_link_if.controller     link,
    // target pin drives
    output logic               multibyte_mode,
    output logic               write_inhibit_input,
    output logic               protect_enable
);
    import ewp_pkg::*;

    // ==========================================
    // state
    typedef struct packed {
        ewp_ctl_state_type st;     // sequencer state
        logic [7:0]        qcnt;   // quarter-bit timer
        logic [1:0]        ph;     // quarter phase
        logic [3:0]        bit_i;  // bit in byte, 8 is ack
        logic [3:0]        byte_i; // byte index
        logic              scl;    // clock out
        logic              sda_oe; // pull data low
        logic [1:0]        sda_s;  // data synchroniser
        logic [2:0]        sel;    // block and chip selects
        logic [2:0]        cnt;    // data bytes minus one
        logic [7:0]        baddr;  // byte address
        logic [63:0]       data;   // data bytes
        logic [2:0]        pins;   // mode, inhibit, protect
        logic              busy;   // sequence running
        logic              nack;   // select or byte refused
        logic [31:0]       prdata; // read data
    } ewp_ctl_reg_type;

    ewp_ctl_reg_type r_ff;   // registered state
    ewp_ctl_reg_type nxt_r;  // next state

    // byte k of the outgoing write
    function automatic ewp_byte_type byte_at(input ewp_ctl_reg_type s, input logic [3:0] k);
        if (k == 4'h0) begin
            // chip selects go out before the block bit
            byte_at = {`EWP_TYPE_ID, s.sel[1:0], s.sel[2], 1'b0};
        end else if (k == 4'h1) begin
            byte_at = s.baddr;
        end else begin
            byte_at = s.data[8 * (k - 4'h2) +: 8];
        end
    endfunction

    // ==========================================
    // next-state logic
    always_comb begin
        logic tick;
        logic wr;
        ewp_byte_type cur;
        nxt_r = r_ff;
        nxt_r.sda_s = {r_ff.sda_s[0], link.sda};
        tick = (r_ff.qcnt == 8'(QTR_CYC - 1));
        wr = psel && penable && pwrite;
        cur = byte_at(r_ff, r_ff.byte_i);
        // register read in setup cycle
        if (psel && !penable) begin
            case (paddr)
                `EWP_REG_CMD:  nxt_r.prdata = {25'h0, r_ff.sel, r_ff.cnt, 1'b0};
                `EWP_REG_ADDR: nxt_r.prdata = {24'h0, r_ff.baddr};
                `EWP_REG_DLO:  nxt_r.prdata = r_ff.data[31:0];
                `EWP_REG_DHI:  nxt_r.prdata = r_ff.data[63:32];
                `EWP_REG_STAT: nxt_r.prdata = {30'h0, r_ff.nack, r_ff.busy};
                `EWP_REG_PINS: nxt_r.prdata = {29'h0, r_ff.pins};
                default:       nxt_r.prdata = 32'h0000_0000;
            endcase
        end
        // register writes, ignored while busy except pins
        if (wr && !r_ff.busy) begin
            case (paddr)
                `EWP_REG_CMD: begin
                    nxt_r.sel = pwdata[`EWP_CMD_SEL];
                    nxt_r.cnt = pwdata[`EWP_CMD_CNT];
                    if (pwdata[`EWP_CMD_GO]) begin
                        nxt_r.busy = 1'b1;
                        nxt_r.nack = 1'b0;
                        nxt_r.st = ctl_start;
                        nxt_r.ph = 2'h0;
                        nxt_r.qcnt = '0;
                    end
                end
                `EWP_REG_ADDR: nxt_r.baddr = pwdata[7:0];
                `EWP_REG_DLO:  nxt_r.data[31:0] = pwdata;
                `EWP_REG_DHI:  nxt_r.data[63:32] = pwdata;
                default: ;
            endcase
        end
        if (wr && paddr == `EWP_REG_PINS) begin
            nxt_r.pins = pwdata[2:0];
        end
        // quarter-bit pacing
        if (r_ff.st != ctl_idle) begin
            nxt_r.qcnt = tick ? 8'h00 : r_ff.qcnt + 8'h01;
            if (tick) begin
                nxt_r.ph = r_ff.ph + 2'h1;
            end
        end
        case (r_ff.st)
            ctl_start: begin
                // data falls while clock high
                nxt_r.scl = (r_ff.ph != 2'h3);
                nxt_r.sda_oe = (r_ff.ph != 2'h0);
                if (tick && r_ff.ph == 2'h3) begin
                    nxt_r.st = ctl_byte;
                    nxt_r.bit_i = '0;
                    nxt_r.byte_i = '0;
                end
            end
            ctl_byte: begin
                nxt_r.scl = (r_ff.ph == 2'h1) || (r_ff.ph == 2'h2);
                nxt_r.sda_oe = (r_ff.bit_i != 4'h8) && !cur[3'(7 - r_ff.bit_i)];
                if (tick && r_ff.ph == 2'h2 && r_ff.bit_i == 4'h8 && r_ff.sda_s[1]) begin
                    nxt_r.nack = 1'b1;
                end
                if (tick && r_ff.ph == 2'h3) begin
                    if (r_ff.bit_i != 4'h8) begin
                        nxt_r.bit_i = r_ff.bit_i + 4'h1;
                    end else if (r_ff.nack || r_ff.byte_i == {1'b0, r_ff.cnt} + 4'h2) begin
                        nxt_r.st = ctl_stop;
                    end else begin
                        nxt_r.bit_i = '0;
                        nxt_r.byte_i = r_ff.byte_i + 4'h1;
                    end
                end
            end
            ctl_stop: begin
                // data rises while clock high
                nxt_r.scl = (r_ff.ph != 2'h0);
                nxt_r.sda_oe = (r_ff.ph != 2'h3);
                if (tick && r_ff.ph == 2'h3) begin
                    nxt_r.st = ctl_idle;
                    nxt_r.busy = 1'b0;
                    nxt_r.sda_oe = 1'b0;
                end
            end
            default: begin
                nxt_r.scl = 1'b1;
                nxt_r.sda_oe = 1'b0;
            end
        endcase
    end

    // ==========================================
    // state register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r_ff <= '{st: ctl_idle, scl: 1'b1, sda_s: 2'h3, default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ==========================================
    // outputs
    assign prdata = r_ff.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr > `EWP_REG_PINS || paddr[1:0] != 2'h0);
    assign link.scl = r_ff.scl;
    assign link.mst_sda_o = 1'b0;
    assign link.mst_sda_oe = r_ff.sda_oe;
    // mode pin always at a driven level
    assign multibyte_mode = r_ff.pins[0];
    assign write_inhibit_input = r_ff.pins[1];
    assign protect_enable = r_ff.pins[2];
endmodule
`default_nettype wire

/* File: hdl/ewp_link_if.sv */
// two-wire link joining the memory target and its controller
`timescale 1ns/1ps
`default_nettype none
interface ewp_link_if;
    logic scl;        // serial clock, driven by the controller
    logic sda;        // resolved data line, pulled up
    logic mst_sda_o;  // controller data out
    logic mst_sda_oe; // controller drives data
    logic dev_sda_o;  // target data out
    logic dev_sda_oe; // target drives data
    // open-drain wired-and with pull-up
    assign sda = !((mst_sda_oe && !mst_sda_o) || (dev_sda_oe && !dev_sda_o));
    modport target (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport controller (output scl, input sda, output mst_sda_o, output mst_sda_oe);
endinterface
`default_nettype wire

/* File: hdl/ewp_pkg.sv */
// state types for both ends of the protected memory link
package ewp_pkg;
    typedef enum logic [5:0] {
        tgt_idle = 6'b00_0001,
        tgt_dsel = 6'b00_0010,
        tgt_addr = 6'b00_0100,
        tgt_data = 6'b00_1000,
        tgt_skip = 6'b01_0000,
        tgt_prog = 6'b10_0000
    } ewp_tgt_state_type;
    typedef enum logic [3:0] {
        ctl_idle  = 4'b0001,
        ctl_start = 4'b0010,
        ctl_byte  = 4'b0100,
        ctl_stop  = 4'b1000
    } ewp_ctl_state_type;
    typedef logic [7:0] ewp_byte_type;
endpackage

/* File: hdl/ewp_target.sv */
// memory target end: select decode, write modes, program cycle, protection
//
// Notes on behaviour
// - type field must equal 1010
// - next two bits match chip selects
// - bit seven is block, bit eight direction
// - acknowledge a matching select in ninth bit
// - mode high multibyte, low page write
// - accept and acknowledge one address byte
// - write inhibit high leaves memory unchanged
// - byte write works in either mode
// - keep mode input at a valid level
// - multibyte write takes one to eight bytes
// - program time doubles across two rows
// - more than four only from row start
// - page write takes up to eight bytes
// - page counter wraps in low bits
// - stop launches program, inputs then ignored
// - no acknowledge while programming
// - pointer flag and enable protect top
// - pointer upper bits give boundary
// - enable low leaves pointer byte plain
// - multibyte may pass boundary by three
`timescale 1ns/1ps
`default_nettype none
`include "ewp_consts.svh"
module ewp_target #(
    parameter int PROG_CYC = `EWP_PROG_CYC
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // serial link
    ewp_link_if.target link,
    // static device pins
    input  wire logic chip_select_low_bit,
    input  wire logic chip_select_high_bit,
    input  wire logic multibyte_mode,
    input  wire logic write_inhibit_input,
    input  wire logic protect_enable,
    // status
    output logic      program_busy
);
    import ewp_pkg::*;

    // ==========================================
    // state
    typedef struct packed {
        ewp_tgt_state_type      st;     // protocol state
        logic [1:0]             scl_s;  // scl synchroniser
        logic [1:0]             sda_s;  // sda synchroniser
        logic                   scl_p;  // scl previous
        logic                   sda_p;  // sda previous
        logic [4:0]             pin_m;  // pin sync first stage
        logic [4:0]             pin_q;  // pin sync second stage
        logic [7:0]             sh;     // received bits
        logic [3:0]             cnt;    // bits in current byte
        logic                   acking; // driving acknowledge
        logic                   sda_oe; // pull data low
        logic                   blk;    // block number
        logic [7:0]             addr;   // address counter
        logic [8:0]             first;  // first data address
        logic                   mb;     // multibyte mode taken
        logic                   dbl;    // two rows touched
        logic [3:0]             n;      // data bytes taken
        logic [7:0]             lv;     // latch valid
        logic [7:0][8:0]        la;     // latch address
        logic [7:0][7:0]        ld;     // latch data
        logic [19:0]            tmr;    // program timer
        logic [511:0][7:0]      mem;    // array
    } ewp_tgt_reg_type;

    localparam ewp_tgt_reg_type RST = '{st: tgt_idle, mem: {512{`EWP_MEM_FILL}},
                                    scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1,
                                    sda_p: 1'b1, default: '0};

    ewp_tgt_reg_type r_ff;   // registered state
    ewp_tgt_reg_type nxt_r;  // next state

    // protection test for one address
    function automatic logic is_prot(input logic [8:0] a, input logic [7:0] ptr,
                                     input logic pre);
        is_prot = pre && !ptr[`EWP_FLAG_BIT] && a[8] && (a[7:0] >= {ptr[7:3], 3'b000});
    endfunction

    // ==========================================
    // next-state logic
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic [8:0] a;
        logic [2:0] idx;
        logic ok;
        nxt_r = r_ff;
        // two-flop synchronisers
        nxt_r.scl_s = {r_ff.scl_s[0], link.scl};
        nxt_r.sda_s = {r_ff.sda_s[0], link.sda};
        nxt_r.scl_p = r_ff.scl_s[1];
        nxt_r.sda_p = r_ff.sda_s[1];
        nxt_r.pin_m = {protect_enable, write_inhibit_input, multibyte_mode,
                       chip_select_high_bit, chip_select_low_bit};
        nxt_r.pin_q = r_ff.pin_m;
        scl_rise = r_ff.scl_s[1] && !r_ff.scl_p;
        scl_fall = !r_ff.scl_s[1] && r_ff.scl_p;
        start_c = r_ff.scl_s[1] && r_ff.scl_p && r_ff.sda_p && !r_ff.sda_s[1];
        stop_c = r_ff.scl_s[1] && r_ff.scl_p && !r_ff.sda_p && r_ff.sda_s[1];
        a = {r_ff.blk, r_ff.addr};
        idx = r_ff.mb ? r_ff.n[2:0] : r_ff.addr[2:0];
        ok = 1'b0;
        case (r_ff.st)
            tgt_prog: begin
                if (r_ff.tmr == 20'h0_0000) begin
                    // commit latched bytes
                    for (int i = 0; i < 8; i++) begin
                        if (r_ff.lv[i]) begin
                            nxt_r.mem[r_ff.la[i]] = r_ff.ld[i];
                        end
                    end
                    nxt_r.lv = '0;
                    nxt_r.st = tgt_idle;
                end else begin
                    nxt_r.tmr = r_ff.tmr - 20'h0_0001;
                end
            end
            default: begin
                if (start_c) begin
                    // a start outside programming resets the byte engine
                    nxt_r.st = tgt_dsel;
                    nxt_r.cnt = '0;
                    nxt_r.acking = 1'b0;
                    nxt_r.sda_oe = 1'b0;
                    nxt_r.n = '0;
                    nxt_r.lv = '0;
                    nxt_r.dbl = 1'b0;
                end else if (stop_c) begin
                    nxt_r.sda_oe = 1'b0;
                    nxt_r.acking = 1'b0;
                    if (r_ff.st == tgt_data && r_ff.n != 4'h0) begin
                        nxt_r.st = tgt_prog;
                        nxt_r.tmr = r_ff.dbl ? 20'(2 * PROG_CYC - 1) : 20'(PROG_CYC - 1);
                    end else begin
                        nxt_r.st = tgt_idle;
                        nxt_r.lv = '0;
                    end
                // a skipped frame still ends its own acknowledge
                end else if (r_ff.st != tgt_idle && (r_ff.st != tgt_skip || r_ff.acking)) begin
                    if (scl_rise && r_ff.cnt < 4'h8) begin
                        // shift in msb first
                        nxt_r.sh = {r_ff.sh[6:0], r_ff.sda_s[1]};
                        nxt_r.cnt = r_ff.cnt + 4'h1;
                    end else if (scl_fall && r_ff.acking) begin
                        // end of acknowledge bit
                        nxt_r.acking = 1'b0;
                        nxt_r.sda_oe = 1'b0;
                        nxt_r.cnt = '0;
                    end else if (scl_fall && r_ff.cnt == 4'h8) begin
                        nxt_r.acking = 1'b1;
                        nxt_r.sda_oe = 1'b1;
                        case (r_ff.st)
                            tgt_dsel: begin
                                if (r_ff.sh[7:4] == `EWP_TYPE_ID &&
                                    r_ff.sh[3:2] == r_ff.pin_q[1:0] && !r_ff.sh[0]) begin
                                    nxt_r.blk = r_ff.sh[1];
                                    nxt_r.st = tgt_addr;
                                end else if (r_ff.sh[7:4] == `EWP_TYPE_ID &&
                                             r_ff.sh[3:2] == r_ff.pin_q[1:0]) begin
                                    nxt_r.blk = r_ff.sh[1];
                                    nxt_r.st = tgt_skip;
                                end else begin
                                    nxt_r.acking = 1'b0;
                                    nxt_r.sda_oe = 1'b0;
                                    nxt_r.st = tgt_skip;
                                end
                            end
                            tgt_addr: begin
                                nxt_r.addr = r_ff.sh;
                                nxt_r.first = {r_ff.blk, r_ff.sh};
                                nxt_r.mb = r_ff.pin_q[2];
                                nxt_r.st = tgt_data;
                            end
                            tgt_data: begin
                                ok = !r_ff.pin_q[3] &&
                                     !(r_ff.mb ? is_prot(r_ff.first, r_ff.mem[`EWP_PTR_ADDR],
                                                         r_ff.pin_q[4])
                                               : is_prot(a, r_ff.mem[`EWP_PTR_ADDR],
                                                         r_ff.pin_q[4]));
                                // extra bytes land in next slots
                                if (ok) begin
                                    nxt_r.lv[idx] = 1'b1;
                                    nxt_r.la[idx] = a;
                                    nxt_r.ld[idx] = r_ff.sh;
                                end
                                if (r_ff.n != 4'hf) begin
                                    nxt_r.n = r_ff.n + 4'h1;
                                end
                                if (r_ff.mb) begin
                                    nxt_r.addr = r_ff.addr + 8'h01;
                                    if (a[7:2] != r_ff.first[7:2]) begin
                                        nxt_r.dbl = 1'b1;
                                    end
                                end else begin
                                    nxt_r.addr = {r_ff.addr[7:3], r_ff.addr[2:0] + 3'h1};
                                end
                            end
                            default: begin
                                nxt_r.acking = 1'b0;
                                nxt_r.sda_oe = 1'b0;
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    // ==========================================
    // state register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r_ff <= RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ==========================================
    // outputs
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = r_ff.sda_oe;
    assign program_busy = (r_ff.st == tgt_prog);
endmodule
`default_nettype wire
